// ===== hw/pbsp_defs.svh
// constants for the pipelined burst sram port
`ifndef PBSP_DEFS_SVH
`define PBSP_DEFS_SVH

`define PBSP_ADDR_W 18
`define PBSP_LANES 4
`define PBSP_LANE_DATA_W 8
`define PBSP_DATA_W 32
`define PBSP_WORD_W 36
`define PBSP_BURST_W 2
`define PBSP_DEPTH 262144
`define PBSP_BURST_ZERO 2'h0
`define PBSP_BURST_ONE 2'h1
`define PBSP_LANES_NONE 4'h0
`define PBSP_LANES_ALL 4'hf
`define PBSP_ADDR_RST 18'h00000
`define PBSP_DATA_RST 32'h00000000
`define PBSP_PARITY_RST 4'h0

`endif

// ===== hw/pbsp_pkg.sv
// types shared by the pipelined burst sram port
`include "pbsp_defs.svh"

package pbsp_pkg;

    typedef enum logic [1:0] {
        PBSP_DESEL = 2'b00,
        PBSP_SELECTED = 2'b01,
        PBSP_SLEEP = 2'b10
    } pbsp_state_t;

    // one array write: address, lane mask and the captured word
    typedef struct packed {
        logic en;
        logic [`PBSP_ADDR_W-1:0] addr;
        logic [`PBSP_LANES-1:0] lanes;
        logic [`PBSP_DATA_W-1:0] data;
        logic [`PBSP_LANES-1:0] parity;
    } pbsp_wr_t;

    // synchronous control pins as sampled at one edge
    typedef struct packed {
        logic procStrobeN;
        logic ctrlStrobeN;
        logic advanceN;
        logic globalWriteN;
        logic byteWriteEnableN;
        logic [`PBSP_LANES-1:0] laneSelN;
        logic selFirstN;
        logic selSecond;
        logic selThirdN;
    } pbsp_ctl_t;

endpackage

// ===== hw/pbsp_burst_ctr.sv
// two-bit wraparound burst counter, linear or interleaved order
module pbsp_burst_ctr
    import pbsp_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic load,
    input wire logic [`PBSP_BURST_W-1:0] startVal,
    input wire logic advance,
    input wire logic interleaved,
    output logic [`PBSP_BURST_W-1:0] curLow,
    output logic [`PBSP_BURST_W-1:0] nextLow
);

    logic [`PBSP_BURST_W-1:0] start_q;
    logic [`PBSP_BURST_W-1:0] start_d;
    logic [`PBSP_BURST_W-1:0] step_q;
    logic [`PBSP_BURST_W-1:0] step_d;
    logic [`PBSP_BURST_W-1:0] stepNext;

    function automatic logic [`PBSP_BURST_W-1:0] burstAddr(
        input logic [`PBSP_BURST_W-1:0] base,
        input logic [`PBSP_BURST_W-1:0] step,
        input logic ilv
    );
        // wraps inside four locations either way
        burstAddr = ilv ? (base ^ step) : (base + step);
    endfunction

    always_comb begin
        stepNext = step_q + `PBSP_BURST_ONE;
        start_d = start_q;
        step_d = step_q;
        if (load) begin
            start_d = startVal;
            step_d = `PBSP_BURST_ZERO;
        end else if (advance) begin
            step_d = stepNext;
        end
        curLow = burstAddr(start_q, step_q, interleaved);
        nextLow = burstAddr(start_q, stepNext, interleaved);
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            start_q <= `PBSP_BURST_ZERO;
            step_q <= `PBSP_BURST_ZERO;
        end else begin
            start_q <= start_d;
            step_q <= step_d;
        end
    end

endmodule

// ===== hw/pbsp_array.sv
// storage array with per-lane writes and combinational read
module pbsp_array
    import pbsp_pkg::*;
(
    input wire logic ref_clk,
    input pbsp_wr_t wrReq,
    input wire logic [`PBSP_ADDR_W-1:0] rdAddr,
    output logic [`PBSP_DATA_W-1:0] rdData,
    output logic [`PBSP_LANES-1:0] rdParity
);

    localparam int LaneW = `PBSP_LANE_DATA_W + 1;

    // each word is four lanes of eight data bits plus one parity bit
    logic [`PBSP_WORD_W-1:0] mem [0:`PBSP_DEPTH-1];
    logic [`PBSP_WORD_W-1:0] rdWord;

    // one process owns the whole array, so the lanes cannot be split across drivers
    always_ff @(posedge ref_clk) begin
        for (int ln = 0; ln < `PBSP_LANES; ln++) begin
            if (wrReq.en && wrReq.lanes[ln]) begin
                mem[wrReq.addr][ln*LaneW +: LaneW] <= {wrReq.parity[ln],
                    wrReq.data[ln*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W]};
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PBSP_LANES; g = g + 1) begin : gLane
            assign rdData[g*`PBSP_LANE_DATA_W +: `PBSP_LANE_DATA_W] =
                rdWord[g*LaneW +: `PBSP_LANE_DATA_W];
            assign rdParity[g] = rdWord[g*LaneW + `PBSP_LANE_DATA_W];
        end
    endgenerate

    assign rdWord = mem[rdAddr];

endmodule

// ===== hw/pbsp_top.sv
// pipelined burst sram port: strobes, selects, burst, writes, output pipe
//
// Behaviour
// - address captured only on an accepted strobe with all selects active
// - two lowest address bits feed the two-bit burst counter
// - a lane select writes its lane only with byte write enable low
// - global write low writes every lane, ignoring lane selects and enable
// - burst counter steps when advance low, holds when advance high
// - processor strobe ignored while first select is high
// - selects sampled only on strobe edges, ignored on advance edges
// - first and third selects active low, second active high, all needed
// - variant without third select treats it as always active
// - output enable low drives data pins, high three-states them
// - first read clock after deselect keeps outputs three-stated
// - advance low during a burst steps the internal burst address
// - accepted strobe with all selects active loads address registers and preloads burst counter
// - both strobes low: the processor strobe acts, the controller strobe instead while first select is high
// - sleep input high holds contents and stops all activity
// - input data and parity captured on the rising edge
// - read data appears one edge after its address edge
// - burst order strap low linear, high interleaved, held static
// - counter captures burst start and wraps within four locations
// - deselect through selects and a strobe three-states outputs at once
module pbsp_top
    import pbsp_pkg::*;
#(
    parameter bit HasThirdSel = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [`PBSP_ADDR_W-1:0] addrIn,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_enable_n,
    input wire logic [`PBSP_LANES-1:0] byte_lane_select_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic outputEnable_n,
    input wire logic sleep_request,
    input wire logic burstOrderStrap,
    input wire logic [`PBSP_DATA_W-1:0] dataIn,
    output logic [`PBSP_DATA_W-1:0] dataOut,
    output logic dataOutEn,
    input wire logic [`PBSP_LANES-1:0] parity_io_in,
    output logic [`PBSP_LANES-1:0] parity_io_out,
    output logic parity_io_oe,
    output logic sleepActive
);

    localparam logic [`PBSP_ADDR_W-1:0] AddrRst = `PBSP_ADDR_RST;

    pbsp_ctl_t ctl;
    pbsp_wr_t wrReq;

    pbsp_state_t state_q;
    pbsp_state_t state_d;
    logic [`PBSP_ADDR_W-`PBSP_BURST_W-1:0] addrHigh_q;
    logic [`PBSP_ADDR_W-`PBSP_BURST_W-1:0] addrHigh_d;
    logic interleaved_q;
    logic interleaved_d;

    logic [`PBSP_ADDR_W-1:0] rdAddr_q;
    logic [`PBSP_ADDR_W-1:0] rdAddr_d;
    logic rdPend_q;
    logic rdPend_d;
    logic firstMask_q;
    logic firstMask_d;
    logic outActive_q;
    logic outActive_d;
    logic [`PBSP_DATA_W-1:0] dataOut_q;
    logic [`PBSP_DATA_W-1:0] dataOut_d;
    logic [`PBSP_LANES-1:0] parityOut_q;
    logic [`PBSP_LANES-1:0] parityOut_d;
    logic sleep_q;
    logic sleep_d;

    logic procStrobe;
    logic load;
    logic chipSel;
    logic selected;
    logic selNow;
    logic advNow;
    logic deselNow;
    logic doWrite;
    logic doRead;
    logic [`PBSP_LANES-1:0] laneMask;
    logic [`PBSP_ADDR_W-1:0] accAddr;
    logic [`PBSP_BURST_W-1:0] curLow;
    logic [`PBSP_BURST_W-1:0] nextLow;
    logic [`PBSP_DATA_W-1:0] rdData;
    logic [`PBSP_LANES-1:0] rdParity;

    // selects are only meaningful on a strobe edge
    function automatic logic allSelectsActive(input pbsp_ctl_t c, input logic hasThird);
        allSelectsActive = !c.selFirstN && c.selSecond
            && (!c.selThirdN || !hasThird);
    endfunction

    function automatic logic [`PBSP_LANES-1:0] writeLanes(input pbsp_ctl_t c);
        if (!c.globalWriteN) begin
            writeLanes = `PBSP_LANES_ALL;
        end else if (!c.byteWriteEnableN) begin
            writeLanes = ~c.laneSelN;
        end else begin
            writeLanes = `PBSP_LANES_NONE;
        end
    endfunction

    always_comb begin
        ctl.procStrobeN = processor_addr_strobe_n;
        ctl.ctrlStrobeN = controller_addr_strobe_n;
        ctl.advanceN = burst_advance_n;
        ctl.globalWriteN = global_write_n;
        ctl.byteWriteEnableN = byte_write_enable_n;
        ctl.laneSelN = byte_lane_select_n;
        ctl.selFirstN = chip_sel_first_n;
        ctl.selSecond = chip_sel_second;
        ctl.selThirdN = chip_sel_third_n;
    end

    // access decode for this edge
    always_comb begin
        selected = (state_q == PBSP_SELECTED);
        // processor strobe wins over controller strobe unless first select is high
        procStrobe = !ctl.procStrobeN && !ctl.selFirstN;
        load = !sleep_request && (procStrobe || !ctl.ctrlStrobeN);
        chipSel = allSelectsActive(ctl, HasThirdSel);
        selNow = load ? chipSel : selected;
        deselNow = load && !chipSel;
        advNow = !load && selected && !sleep_request && !ctl.advanceN;
        laneMask = writeLanes(ctl);
        // a processor-strobe edge only opens the access; write controls act later
        doWrite = !sleep_request && selNow && !(load && procStrobe)
            && (laneMask != `PBSP_LANES_NONE);
        doRead = !sleep_request && selNow && !doWrite;
        if (load) begin
            accAddr = addrIn;
        end else if (advNow) begin
            accAddr = {addrHigh_q, nextLow};
        end else begin
            accAddr = {addrHigh_q, curLow};
        end
    end

    // selection state, address register and burst order strap
    always_comb begin
        state_d = state_q;
        addrHigh_d = addrHigh_q;
        interleaved_d = interleaved_q;
        sleep_d = sleep_request;
        if (sleep_request) begin
            // contents kept, no access runs until the input drops
            state_d = PBSP_SLEEP;
        end else if (load && chipSel) begin
            state_d = PBSP_SELECTED;
            addrHigh_d = addrIn[`PBSP_ADDR_W-1:`PBSP_BURST_W];
        end else if (load || state_q == PBSP_SLEEP) begin
            state_d = PBSP_DESEL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_q <= PBSP_DESEL;
            addrHigh_q <= AddrRst[`PBSP_ADDR_W-1:`PBSP_BURST_W];
            // strap is caught while reset is held and then frozen
            interleaved_q <= burstOrderStrap;
            sleep_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addrHigh_q <= addrHigh_d;
            interleaved_q <= interleaved_d;
            sleep_q <= sleep_d;
        end
    end

    pbsp_burst_ctr uBurst (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .load(load && chipSel),
        .startVal(addrIn[`PBSP_BURST_W-1:0]),
        .advance(advNow),
        .interleaved(interleaved_q),
        .curLow(curLow),
        .nextLow(nextLow)
    );

    // write data captured on the same edge as its controls
    always_comb begin
        wrReq.en = doWrite;
        wrReq.addr = accAddr;
        wrReq.lanes = laneMask;
        wrReq.data = dataIn;
        wrReq.parity = parity_io_in;
    end

    pbsp_array uArray (
        .ref_clk(ref_clk),
        .wrReq(wrReq),
        .rdAddr(rdAddr_q),
        .rdData(rdData),
        .rdParity(rdParity)
    );

    // read pipe: address edge, then output register edge
    always_comb begin
        rdAddr_d = doRead ? accAddr : rdAddr_q;
        rdPend_d = doRead;
        // emerging from deselect: this access gets no output in its first clock
        firstMask_d = doRead && load && (state_q != PBSP_SELECTED);
        // the masked access still loads its data, only the drive is withheld
        outActive_d = rdPend_q && !firstMask_q && !firstMask_d
            && !deselNow && !sleep_request;
        dataOut_d = rdPend_q ? rdData : dataOut_q;
        parityOut_d = rdPend_q ? rdParity : parityOut_q;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            rdAddr_q <= `PBSP_ADDR_RST;
            rdPend_q <= 1'b0;
            firstMask_q <= 1'b0;
            outActive_q <= 1'b0;
            dataOut_q <= `PBSP_DATA_RST;
            parityOut_q <= `PBSP_PARITY_RST;
        end else begin
            rdAddr_q <= rdAddr_d;
            rdPend_q <= rdPend_d;
            firstMask_q <= firstMask_d;
            outActive_q <= outActive_d;
            dataOut_q <= dataOut_d;
            parityOut_q <= parityOut_d;
        end
    end

    // the output enable is asynchronous, so the drive gate cannot be registered
    assign dataOutEn = outActive_q && !firstMask_q && !outputEnable_n;
    assign parity_io_oe = outActive_q && !firstMask_q && !outputEnable_n;
    assign dataOut = dataOut_q;
    assign parity_io_out = parityOut_q;
    assign sleepActive = sleep_q;

endmodule

// ===== verification/pbsp_chk.sv
// pin-level assertions for the sram port, bound to the top module
`include "pbsp_defs.svh"
module pbsp_chk #(
    parameter bit HasThirdSel = 1'b1
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic chip_sel_first_n,
    input wire logic chip_sel_second,
    input wire logic chip_sel_third_n,
    input wire logic outputEnable_n,
    input wire logic sleep_request,
    input wire logic [`PBSP_DATA_W-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic parity_io_oe,
    input wire logic sleepActive
);
    logic loadNow;
    logic selOk;
    // processor strobe only counts with the first select low
    assign loadNow = !sleep_request && (!controller_addr_strobe_n
        || (!processor_addr_strobe_n && !chip_sel_first_n));
    assign selOk = !chip_sel_first_n && chip_sel_second && (!chip_sel_third_n || !HasThirdSel);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    a_oe_blocks: assert property (outputEnable_n |-> !dataOutEn)
        else $error("data pins driven with output enable high");
    a_oe_pair: assert property (parity_io_oe == dataOutEn)
        else $error("parity and data enables differ");
    a_sleep_follow: assert property ($past(rst_b) |-> sleepActive == $past(sleep_request))
        else $error("sleep flag not one edge behind request");
    a_sleep_quiet: assert property (sleepActive |-> !dataOutEn)
        else $error("pins driven while asleep");
    a_sleep_hold: assert property ($past(sleepActive) && sleepActive |-> $stable(dataOut))
        else $error("read data moved during sleep");
    a_reset_quiet: assert property ($rose(rst_b) |-> !dataOutEn ##1 !dataOutEn)
        else $error("pins driven too soon after reset");
    a_desel_off: assert property (loadNow && !selOk |=> !dataOutEn)
        else $error("pins still driven after deselect");
    a_desel_hold: assert property ((loadNow && !selOk) ##1 !loadNow |=> !dataOutEn)
        else $error("deselected port drove its pins");
endmodule
bind pbsp_top pbsp_chk #(.HasThirdSel(HasThirdSel)) i_pbsp_chk (.ref_clk(ref_clk),
    .rst_b(rst_b), .processor_addr_strobe_n(processor_addr_strobe_n),
    .controller_addr_strobe_n(controller_addr_strobe_n), .chip_sel_first_n(chip_sel_first_n),
    .chip_sel_second(chip_sel_second), .chip_sel_third_n(chip_sel_third_n),
    .outputEnable_n(outputEnable_n), .sleep_request(sleep_request), .dataOut(dataOut),
    .dataOutEn(dataOutEn), .parity_io_oe(parity_io_oe), .sleepActive(sleepActive));

// ===== verification/pbsp_ctrl_model.sv
// cache controller model: puts requested pin values out at the falling edge
`include "pbsp_defs.svh"
module pbsp_ctrl_model
    import pbsp_pkg::*;
(
    input wire logic ref_clk,
    input pbsp_ctl_t reqCtl,
    input wire logic [`PBSP_ADDR_W-1:0] reqAddr,
    input wire logic [`PBSP_WORD_W-1:0] reqWord,
    input wire logic reqDrive,
    output pbsp_ctl_t pinCtl,
    output logic [`PBSP_ADDR_W-1:0] pinAddr,
    output logic [`PBSP_WORD_W-1:0] pinWord
);
    initial begin
        pinCtl = '1;
        pinAddr = '0;
        pinWord = '0;
    end
    always @(negedge ref_clk) begin
        pinCtl <= reqCtl;
        pinAddr <= reqAddr;
        // released lines toggle so a stale value is never mistaken for data
        pinWord <= reqDrive ? reqWord : ~pinWord;
    end
endmodule

// ===== verification/pbsp_bench.sv
// self-checking bench for the pipelined burst sram port
`include "pbsp_defs.svh"
module pbsp_bench
    import pbsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [2:0] SEL = 3'b010;
    logic ref_clk = 1'b0, rst_b = 1'b0, oeN = 1'b1, sleepReq = 1'b0, strap = 1'b0;
    pbsp_ctl_t req, pc;
    logic [17:0] rAddr, pa, base;
    logic [35:0] rWord, pw;
    logic rDrive;
    logic [31:0] dataOut;
    logic [3:0] parOut;
    logic dataOutEn, parOe, sleepActive;
    logic [35:0] mem [int];
    int errors = 0, samples_checked = 0;
    logic [2:0] bad [3] = '{3'b110, 3'b000, 3'b011};
    always #25 ref_clk = ~ref_clk;
    pbsp_ctrl_model i_pbsp_ctrl_model (.ref_clk(ref_clk), .reqCtl(req), .reqAddr(rAddr),
        .reqWord(rWord), .reqDrive(rDrive), .pinCtl(pc), .pinAddr(pa), .pinWord(pw));
    pbsp_top i_pbsp_top (.ref_clk(ref_clk), .rst_b(rst_b), .addrIn(pa),
        .processor_addr_strobe_n(pc.procStrobeN), .controller_addr_strobe_n(pc.ctrlStrobeN),
        .burst_advance_n(pc.advanceN), .global_write_n(pc.globalWriteN),
        .byte_write_enable_n(pc.byteWriteEnableN), .byte_lane_select_n(pc.laneSelN),
        .chip_sel_first_n(pc.selFirstN), .chip_sel_second(pc.selSecond),
        .chip_sel_third_n(pc.selThirdN), .outputEnable_n(oeN), .sleep_request(sleepReq),
        .burstOrderStrap(strap), .dataIn(pw[31:0]), .dataOut(dataOut), .dataOutEn(dataOutEn),
        .parity_io_in(pw[35:32]), .parity_io_out(parOut), .parity_io_oe(parOe),
        .sleepActive(sleepActive));
    function automatic pbsp_ctl_t mk(logic p, logic c, logic v, logic g, logic b,
        logic [3:0] ln, logic [2:0] s);
        return '{p, c, v, g, b, ln, s[2], s[1], s[0]};
    endfunction
    function automatic logic [35:0] rnd();
        logic [63:0] r;
        r = {$urandom, $urandom};
        return r[35:0];
    endfunction
    function automatic logic [35:0] merge(logic [35:0] o, logic [35:0] n, logic [3:0] ln);
        for (int g = 0; g < 4; g++) begin
            if (ln[g]) begin
                o[8*g+:8] = n[8*g+:8];
                o[32+g] = n[32+g];
            end
        end
        return o;
    endfunction
    function automatic logic [1:0] order(logic [1:0] s, logic [1:0] k);
        return strap ? s ^ k : s + k;
    endfunction
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk_w(logic [35:0] g, logic [35:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t read word %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk_b(logic g, logic e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("ERROR %0t flag %b expected %b", $time, g, e);
        end
    endtask
    // request is set after an edge, the model puts it out at the falling edge
    task automatic step(pbsp_ctl_t c, logic [17:0] a, logic [35:0] w, logic d, logic o,
        logic s);
        req = c;
        rAddr = a;
        rWord = w;
        rDrive = d;
        @(negedge ref_clk);
        oeN <= o;
        sleepReq <= s;
        @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(logic [17:0] a, logic [35:0] w, logic g, logic b, logic [3:0] ln);
        step(mk(1, 0, 1, g, b, ln, SEL), a, w, 1, 0, 0);
        mem[a] = merge(mem[a], w, !g ? 4'hf : !b ? ~ln : 4'h0);
    endtask
    // advance edges carry junk selects and an ignored processor strobe
    task automatic burst(pbsp_ctl_t ld, logic [17:0] a, int n, logic ds, logic o);
        logic [2:0] s;
        step(ld, a, rnd(), 1, o, 0);
        for (int i = 1; i <= n; i++) begin
            s = 3'($urandom);
            if (i < n)
                step(mk(!s[2], 1, 0, 1, 1, 4'hf, s), 18'($urandom), 0, 0, o, 0);
            else
                step(mk(1, 1, 1, 1, 1, 4'hf, s), 18'($urandom), 0, 0, o, 0);
            chk_w({parOut, dataOut}, mem[{a[17:2], order(a[1:0], 2'(i - 1))}]);
            chk_b(dataOutEn, !o && !(i == 1 && ds));
        end
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        errors++;
        report_and_stop();
    end
    initial begin
        req = mk(1, 1, 1, 1, 1, 4'hf, SEL);
        rAddr = '0;
        rWord = '0;
        rDrive = 1'b0;
        base = 18'($urandom(32'h2034));
        for (int m = 0; m < 2; m++) begin
            req = mk(1, 1, 1, 1, 1, 4'hf, SEL);
            @(negedge ref_clk);
            rst_b <= 1'b0;
            strap <= m[0];
            repeat (12) @(negedge ref_clk);
            rst_b <= 1'b1;
            @(posedge ref_clk);
            #1;
            chk_w({parOut, dataOut}, '0);
            chk_b(dataOutEn, 1'b0);
            base = {16'($urandom), 2'h0};
            for (int i = 0; i < 4; i++) wr(base + 18'(i), rnd(), 0, 1, 4'hf);
            wr(base + 1, rnd(), 1, 0, 4'($urandom));
            wr(base + 2, rnd(), 1, 1, 4'h0);
            wr(base + 3, rnd(), 0, 1, 4'hf);
            step(mk(1, 1, 1, 1, 1, 4'hf, SEL), 0, 0, 0, 0, 1);
            chk_b(sleepActive, 1'b1);
            step(mk(1, 0, 1, 0, 1, 4'hf, SEL), base, rnd(), 1, 0, 1);
            step(mk(1, 1, 1, 1, 1, 4'hf, SEL), 0, 0, 0, 0, 0);
            chk_b(sleepActive, 1'b0);
            burst(mk(1, 0, 1, 1, 1, 4'hf, SEL), base + 2, 4, 1, 0);
            burst(mk(0, 0, 1, 0, 1, 4'hf, SEL), base + 1, 4, 0, 0);
            burst(mk(0, 1, 1, 1, 1, 4'hf, SEL), base + 3, 2, 0, 1);
            for (int j = 0; j < 3; j++) begin
                burst(mk(1, 0, 1, 1, 1, 4'hf, SEL), base, 2, j != 0, 0);
                step(mk(1, 0, 1, 1, 1, 4'hf, bad[j]), base, 0, 0, 0, 0);
                chk_b(dataOutEn, 1'b0);
                step(mk(0, 1, 1, 1, 1, 4'hf, 3'b110), base, 0, 0, 0, 0);
                chk_b(dataOutEn, 1'b0);
            end
            for (int r = 0; r < 12; r++) begin
                wr(base + 18'($urandom % 4), rnd(), $urandom % 2, 0, 4'($urandom));
                s_rnd(r);
            end
        end
        report_and_stop();
    end
    task automatic s_rnd(int r);
        logic p;
        p = r[0];
        burst(mk(p, !p, 1, 1, 1, 4'hf, SEL), base + 18'($urandom % 4), 1 + $urandom % 4, 0, 0);
    endtask
endmodule
